// ### src/picture_adjust_consts.svh
// offsets, reset values, field positions and scaling for the picture adjust stage
// assumes inclusion by bare name from the design module, the checker and the bench
`ifndef PICTURE_ADJUST_CONSTS_SVH
`define PICTURE_ADJUST_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_LUMA_FILTER_CONTROL 8'h09
`define OFS_LUMA_BRIGHTNESS     8'h0a
`define OFS_LUMA_CONTRAST       8'h0b
`define OFS_CHROMA_SATURATION   8'h0c
`define OFS_CHROMA_HUE          8'h0d

// ----------------------------------------------------------------------------
// reset values (nominal picture)
// ----------------------------------------------------------------------------
`define RST_LUMA_FILTER_CONTROL 8'h00
`define RST_LUMA_BRIGHTNESS     8'h80
`define RST_LUMA_CONTRAST       8'h44
`define RST_CHROMA_SATURATION   8'h40
`define RST_CHROMA_HUE          8'h00

// ----------------------------------------------------------------------------
// fields and arithmetic
// ----------------------------------------------------------------------------
`define SHARP_MSB       3
`define SHARP_LSB       0
`define GAIN_SHIFT      6
`define BRIGHT_NOMINAL  20'sh00080
`define HUE_QUARTER     8'h40
`define HUE_HALF        16'h0080

`endif

// ### src/picture_adjust_pkg.sv
// types shared by the picture adjust stage
// assumes the consts header is on the include path
`default_nettype none

package picture_adjust_pkg;

	// one video sample: unsigned luma, two's complement colour difference
	typedef struct packed {
		logic        [7:0] y;
		logic signed [7:0] cb;
		logic signed [7:0] cr;
	} sample_t;

	// symmetric 5-tap kernel: centre, +-1, +-2 (scale 64)
	typedef struct packed {
		logic signed [8:0] c0;
		logic signed [8:0] c1;
		logic signed [8:0] c2;
	} coef_t;

endpackage

`default_nettype wire

// ### src/luma_chroma_picture_adjust.sv
// picture adjust stage: luma sharpness/low-pass, brightness, contrast,
// chroma hue rotation and saturation, plus the five control registers
// assumes samples and register writes arrive synchronous to clk
`include "picture_adjust_consts.svh"
`default_nettype none

module luma_chroma_picture_adjust (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        reg_we,
	input  wire logic                  [7:0] reg_addr,
	input  wire logic                  [7:0] reg_wdata,
	output logic                       [7:0] reg_rdata,
	input  wire logic                        in_valid,
	input  wire picture_adjust_pkg::sample_t in_sample,
	output logic                             out_valid,
	output picture_adjust_pkg::sample_t      out_sample
);

	// ------------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------------

	// kernels sum to 64 so flat areas keep their level
	function automatic picture_adjust_pkg::coef_t kernel(input logic [3:0] code);
		picture_adjust_pkg::coef_t k;
		k = '{c0: 9'sh040, c1: 9'sh000, c2: 9'sh000};
		unique case (code)
			4'h0: k = '{c0: 9'sh040, c1: 9'sh000, c2: 9'sh000};
			4'h1: k = '{c0: 9'sh058, c1: -9'sh00c, c2: 9'sh000};
			4'h2: k = '{c0: 9'sh054, c1: -9'sh00a, c2: 9'sh000};
			4'h3: k = '{c0: 9'sh050, c1: -9'sh008, c2: 9'sh000};
			4'h4: k = '{c0: 9'sh04c, c1: -9'sh006, c2: 9'sh000};
			4'h5: k = '{c0: 9'sh04a, c1: -9'sh005, c2: 9'sh000};
			4'h6: k = '{c0: 9'sh048, c1: -9'sh004, c2: 9'sh000};
			4'h7: k = '{c0: 9'sh046, c1: -9'sh003, c2: 9'sh000};
			4'h8: k = '{c0: 9'sh030, c1: 9'sh008, c2: 9'sh000};
			4'h9: k = '{c0: 9'sh02c, c1: 9'sh00a, c2: 9'sh000};
			4'ha: k = '{c0: 9'sh028, c1: 9'sh00c, c2: 9'sh000};
			4'hb: k = '{c0: 9'sh020, c1: 9'sh010, c2: 9'sh000};
			4'hc: k = '{c0: 9'sh018, c1: 9'sh010, c2: 9'sh004};
			4'hd: k = '{c0: 9'sh014, c1: 9'sh010, c2: 9'sh006};
			4'he: k = '{c0: 9'sh010, c1: 9'sh010, c2: 9'sh008};
			4'hf: k = '{c0: 9'sh010, c1: 9'sh00c, c2: 9'sh00c};
		endcase
		return k;
	endfunction

	// parabolic sine on a 256-step circle, 64 = 1.0, within about 6 percent
	function automatic logic signed [7:0] sine(input logic [7:0] a);
		logic [15:0] h;
		logic [15:0] p;
		h = {9'h000, a[6:0]};
		p = (h * (`HUE_HALF - h)) >> `GAIN_SHIFT;
		return a[7] ? -$signed(p[7:0]) : $signed(p[7:0]);
	endfunction

	// saturate to unsigned 8 bit
	function automatic logic [7:0] clip_u8(input logic signed [19:0] v);
		if (v < 20'sh00000)
			return 8'h00;
		else if (v > 20'sh000ff)
			return 8'hff;
		else
			return v[7:0];
	endfunction

	// saturate to signed 8 bit
	function automatic logic signed [7:0] clip_s8(input logic signed [19:0] v);
		if (v < -20'sh00080)
			return 8'sh80;
		else if (v > 20'sh0007f)
			return 8'sh7f;
		else
			return v[7:0];
	endfunction

	// ------------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------------
	logic [7:0] filter_ctrl_r;
	logic [7:0] brightness_offset_r;
	logic [7:0] contrast_gain_r;
	logic [7:0] saturation_gain_r;
	logic [7:0] hue_phase_r;

	// writes to unmapped offsets are dropped; upper filter bits only stored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filter_ctrl_r       <= `RST_LUMA_FILTER_CONTROL;
			brightness_offset_r <= `RST_LUMA_BRIGHTNESS;
			contrast_gain_r     <= `RST_LUMA_CONTRAST;
			saturation_gain_r   <= `RST_CHROMA_SATURATION;
			hue_phase_r         <= `RST_CHROMA_HUE;
		end else if (reg_we) begin
			unique case (reg_addr)
				`OFS_LUMA_FILTER_CONTROL: filter_ctrl_r       <= reg_wdata;
				`OFS_LUMA_BRIGHTNESS:     brightness_offset_r <= reg_wdata;
				`OFS_LUMA_CONTRAST:       contrast_gain_r     <= reg_wdata;
				`OFS_CHROMA_SATURATION:   saturation_gain_r   <= reg_wdata;
				`OFS_CHROMA_HUE:          hue_phase_r         <= reg_wdata;
				default: ;
			endcase
		end
	end

	// registered read-back, unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				`OFS_LUMA_FILTER_CONTROL: reg_rdata <= filter_ctrl_r;
				`OFS_LUMA_BRIGHTNESS:     reg_rdata <= brightness_offset_r;
				`OFS_LUMA_CONTRAST:       reg_rdata <= contrast_gain_r;
				`OFS_CHROMA_SATURATION:   reg_rdata <= saturation_gain_r;
				`OFS_CHROMA_HUE:          reg_rdata <= hue_phase_r;
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// sample window: five samples, centre is two samples old
	// ------------------------------------------------------------------------
	picture_adjust_pkg::sample_t tap_r [0:4];
	logic                        win_valid_r;

	// window moves only on valid samples so gaps do not smear the filter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 5; i++)
				tap_r[i] <= '0;
			win_valid_r <= 1'b0;
		end else begin
			win_valid_r <= in_valid;
			if (in_valid) begin
				tap_r[0] <= in_sample;
				for (int i = 1; i < 5; i++)
					tap_r[i] <= tap_r[i-1];
			end
		end
	end

	// ------------------------------------------------------------------------
	// stage 1: luma kernel and hue rotation
	// ------------------------------------------------------------------------
	picture_adjust_pkg::coef_t k;
	logic signed [19:0]        luma_acc;
	logic signed [7:0]         hue_cos;
	logic signed [7:0]         hue_sin;
	logic signed [19:0]        cb_rot;
	logic signed [19:0]        cr_rot;

	// luma kernel from the sharpness field
	always_comb begin
		k = kernel(filter_ctrl_r[`SHARP_MSB:`SHARP_LSB]);
		luma_acc = 20'(k.c0) * $signed({12'h000, tap_r[2].y})
			+ 20'(k.c1) * ($signed({12'h000, tap_r[1].y}) + $signed({12'h000, tap_r[3].y}))
			+ 20'(k.c2) * ($signed({12'h000, tap_r[0].y}) + $signed({12'h000, tap_r[4].y}));
	end

	// chroma rotation, angle in units of 180/128 degrees
	always_comb begin
		hue_sin = sine(hue_phase_r);
		hue_cos = sine(hue_phase_r + `HUE_QUARTER);
		cb_rot = (20'(tap_r[2].cb) * 20'(hue_cos) - 20'(tap_r[2].cr) * 20'(hue_sin))
			>>> `GAIN_SHIFT;
		cr_rot = (20'(tap_r[2].cb) * 20'(hue_sin) + 20'(tap_r[2].cr) * 20'(hue_cos))
			>>> `GAIN_SHIFT;
	end

	logic [7:0]         luma_f_r;
	logic signed [19:0] cb_rot_r;
	logic signed [19:0] cr_rot_r;
	logic               s1_valid_r;

	// peaking can overshoot, so clamp before contrast
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			luma_f_r   <= 8'h00;
			cb_rot_r   <= '0;
			cr_rot_r   <= '0;
			s1_valid_r <= 1'b0;
		end else begin
			s1_valid_r <= win_valid_r;
			luma_f_r   <= clip_u8(luma_acc >>> `GAIN_SHIFT);
			cb_rot_r   <= cb_rot;
			cr_rot_r   <= cr_rot;
		end
	end

	// ------------------------------------------------------------------------
	// stage 2: contrast, brightness, saturation
	// ------------------------------------------------------------------------
	logic signed [19:0] luma_adj;
	logic signed [19:0] cb_adj;
	logic signed [19:0] cr_adj;

	// brightness 128 adds nothing; gains are value/64
	always_comb begin
		luma_adj = ((20'($signed({1'b0, luma_f_r})) * 20'($signed(contrast_gain_r)))
			>>> `GAIN_SHIFT)
			+ 20'($signed({1'b0, brightness_offset_r})) - `BRIGHT_NOMINAL;
		cb_adj = (cb_rot_r * 20'($signed(saturation_gain_r))) >>> `GAIN_SHIFT;
		cr_adj = (cr_rot_r * 20'($signed(saturation_gain_r))) >>> `GAIN_SHIFT;
	end

	// output register, saturating rather than wrapping
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid  <= 1'b0;
			out_sample <= '0;
		end else begin
			out_valid     <= s1_valid_r;
			out_sample.y  <= clip_u8(luma_adj);
			out_sample.cb <= clip_s8(cb_adj);
			out_sample.cr <= clip_s8(cr_adj);
		end
	end

endmodule // luma_chroma_picture_adjust

`default_nettype wire

// ### verif/picture_adjust_asserts.sv
// checker: port-level properties of the picture adjust stage
// assumes bind onto luma_chroma_picture_adjust, consts header on include path
`include "picture_adjust_consts.svh"
`default_nettype none

module picture_adjust_asserts (
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic                        reg_we,
	input wire logic                  [7:0] reg_addr,
	input wire logic                  [7:0] reg_wdata,
	input wire logic                  [7:0] reg_rdata,
	input wire logic                        in_valid,
	input wire picture_adjust_pkg::sample_t in_sample,
	input wire logic                        out_valid,
	input wire picture_adjust_pkg::sample_t out_sample
);
	logic [7:0] con_r;
	logic [7:0] bri_r;
	logic [7:0] sat_r;

	// shadow contrast, brightness and saturation, so a settled setting can be tied to the output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			con_r <= `RST_LUMA_CONTRAST;
			bri_r <= `RST_LUMA_BRIGHTNESS;
			sat_r <= `RST_CHROMA_SATURATION;
		end else if (reg_we) begin
			if (reg_addr == `OFS_LUMA_CONTRAST) con_r <= reg_wdata;
			if (reg_addr == `OFS_LUMA_BRIGHTNESS) bri_r <= reg_wdata;
			if (reg_addr == `OFS_CHROMA_SATURATION) sat_r <= reg_wdata;
		end
	end

	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// mapped write, then the address left in place
	sequence s_wr_held;
		reg_we && reg_addr inside {[8'h09:8'h0d]} ##1 reg_addr == $past(reg_addr);
	endsequence
	// contrast zero now, one and three cycles back, brightness the same at those three points
	sequence s_luma_off;
		out_valid && con_r == 8'h00 && $past(con_r, 3) == 8'h00 && bri_r == $past(bri_r, 3)
			&& $past(con_r) == 8'h00 && $past(bri_r) == bri_r;
	endsequence

	a_valid_latency: assert property (in_valid |-> ##3 out_valid)
		else $error("no output three cycles after a sample");
	a_no_spurious: assert property (out_valid |-> $past(in_valid, 3))
		else $error("output without a sample three cycles before");
	a_unmapped_zero: assert property (!(reg_addr inside {[8'h09:8'h0d]}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_write_back: assert property (s_wr_held |=> reg_rdata == $past(reg_wdata, 2))
		else $error("written value not read back");
	a_rdata_hold: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(reg_we)
		&& $stable(reg_addr) |=> $stable(reg_rdata)) else $error("read data moved");
	a_bright_level: assert property (s_luma_off |-> bri_r < 8'h80 || out_sample.y == bri_r - 8'h80)
		else $error("luma off: level not brightness minus 128");
	a_dark_clip: assert property (s_luma_off |-> bri_r >= 8'h80 || out_sample.y == 8'h00)
		else $error("luma off: dark level did not clip to zero");
	a_colour_off: assert property (out_valid && sat_r == 8'h00 && $past(sat_r, 3) == 8'h00
		&& $past(sat_r) == 8'h00
		|-> out_sample.cb == 8'sh00 && out_sample.cr == 8'sh00) else $error("colour not removed");
endmodule // picture_adjust_asserts

bind luma_chroma_picture_adjust picture_adjust_asserts chk_u (.clk(clk), .rst_n(rst_n),
	.reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample));

`default_nettype wire

// ### verif/luma_chroma_picture_adjust_tb.sv
// self-checking bench for the picture adjust stage
// assumes package, consts header and checker are compiled before it
`include "picture_adjust_consts.svh"
`default_nettype none

module luma_chroma_picture_adjust_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        clk, rst_n, reg_we, in_valid, out_valid;
	logic                  [7:0] reg_addr, reg_wdata, reg_rdata;
	picture_adjust_pkg::sample_t in_sample, out_sample;
	int                          bad_count, check_count;
	// kernels centre, +-1, +-2 per sharpness code
	int k[16][3] = '{'{64,0,0}, '{88,-12,0}, '{84,-10,0}, '{80,-8,0}, '{76,-6,0}, '{74,-5,0},
		'{72,-4,0}, '{70,-3,0}, '{48,8,0}, '{44,10,0}, '{40,12,0}, '{32,16,0}, '{24,16,4},
		'{20,16,6}, '{16,16,8}, '{16,12,12}};

	luma_chroma_picture_adjust dut_u (.clk(clk), .rst_n(rst_n), .reg_we(reg_we),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid),
		.in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// idle cycle after the strobe so writes never re-raise it in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
	endtask

	// read data is registered: look one cycle after the address
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		@(posedge clk);
		#1 chk8(reg_rdata, exp);
		@(posedge clk);
	endtask

	// five samples, centre hi among lo; only the centre output is judged
	task automatic frame(input int lo, hi, input logic [7:0] cb, cr, ey, ecb, ecr);
		for (int i = 0; i < 5; i++) begin
			in_valid <= 1'b1;
			in_sample <= {(i == 2) ? hi[7:0] : lo[7:0], cb, cr};
			@(posedge clk);
		end
		in_valid <= 1'b0;
		// last sample lands three edges after it is driven, so two more edges here
		repeat (2) @(posedge clk);
		#1 chk8({7'h00, out_valid}, 8'h01);
		chk8(out_sample.y, ey);
		chk8(out_sample.cb, ecb);
		chk8(out_sample.cr, ecr);
		@(posedge clk);
	endtask

	function automatic logic [7:0] ref_y(int c, lo, hi, con, bri);
		int v;
		v = (k[c][0] * hi + 2 * (k[c][1] + k[c][2]) * lo) >>> 6;
		v = (v < 0) ? 0 : (v > 255) ? 255 : v;
		v = ((v * con) >>> 6) + bri - 128;
		return 8'((v < 0) ? 0 : (v > 255) ? 255 : v);
	endfunction

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] ofs[5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
		logic [7:0] rv[5] = '{`RST_LUMA_FILTER_CONTROL, `RST_LUMA_BRIGHTNESS,
			`RST_LUMA_CONTRAST, `RST_CHROMA_SATURATION, `RST_CHROMA_HUE};
		rd_chk(8'h08, 8'h00);
		rd_chk(8'h0e, 8'h00);
		for (int i = 0; i < 5; i++) begin
			rd_chk(ofs[i], rv[i]);
			wr(ofs[i], 8'ha5 ^ 8'(i));
			rd_chk(ofs[i], 8'ha5 ^ 8'(i));
			wr(ofs[i], rv[i]);
		end
		$display("test regs done");
	endtask

	task automatic t_sharp();
		for (int c = 0; c < 16; c++) begin
			wr(8'h09, {4'h5, 4'(c)});
			frame(64, 128, 8'h00, 8'h00, ref_y(c, 64, 128, 68, 128), 8'h00, 8'h00);
		end
		wr(8'h09, `RST_LUMA_FILTER_CONTROL);
		$display("test sharpness done");
	endtask

	// contrast, brightness, luma per row; covers off, inverse and both clips
	task automatic t_luma();
		logic [23:0] t[6] = '{24'h40_80_64, 24'h00_ff_64, 24'h00_10_64, 24'h80_80_64,
			24'hc0_ff_64, 24'h7f_80_c8};
		logic [7:0]  e;
		for (int i = 0; i < 6; i++) begin
			wr(8'h0b, t[i][23:16]);
			wr(8'h0a, t[i][15:8]);
			e = ref_y(0, t[i][7:0], t[i][7:0], $signed(t[i][23:16]), t[i][15:8]);
			frame(t[i][7:0], t[i][7:0], 8'h00, 8'h00, e, 8'h00, 8'h00);
		end
		wr(8'h0b, `RST_LUMA_CONTRAST);
		wr(8'h0a, `RST_LUMA_BRIGHTNESS);
		$display("test luma done");
	endtask

	// saturation, hue, cb, cr in; cb, cr expected
	task automatic t_chroma();
		logic [47:0] t[8] = '{48'h40_00_32_e2_32_e2, 48'h00_00_32_e2_00_00, 48'hc0_00_32_e2_ce_1e,
			48'h80_00_64_9c_80_7f, 48'h7f_00_64_9c_7f_80, 48'h40_40_32_e2_1e_32,
			48'h40_80_32_e2_ce_1e, 48'h40_7f_32_e2_cf_1e};
		logic [7:0]  e;
		e = ref_y(0, 100, 100, 68, 128);
		for (int i = 0; i < 8; i++) begin
			wr(8'h0c, t[i][47:40]);
			wr(8'h0d, t[i][39:32]);
			frame(100, 100, t[i][31:24], t[i][23:16], e, t[i][15:8], t[i][7:0]);
		end
		$display("test chroma done");
	endtask

	initial begin
		rst_n = 1'b0;
		reg_we = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		in_valid = 1'b0;
		in_sample = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_sharp();
		t_luma();
		t_chroma();
		print_verdict();
	end

	// watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
endmodule // luma_chroma_picture_adjust_tb

`default_nettype wire
